// *** verilog/dfi_pkg.sv ***
// constants and types for the digital frequency input block
package dfi_pkg;
	// input method codes
	localparam logic [13:0] METHOD_BCD3      = 14'h0000;
	localparam logic [13:0] METHOD_BIN12     = 14'h0001;
	localparam logic [13:0] METHOD_BCD3_CMP  = 14'h0002;
	localparam logic [13:0] METHOD_BIN12_CMP = 14'h0003;
	localparam logic [13:0] METHOD_BCD4      = 14'h000a;
	localparam logic [13:0] METHOD_BIN16     = 14'h000b;
	localparam logic [13:0] METHOD_BCD4_CMP  = 14'h000c;
	localparam logic [13:0] METHOD_BIN16_CMP = 14'h000d;
	localparam logic [13:0] METHOD_OFF       = 14'h270f;
	localparam logic [13:0] METHOD_RESET     = 14'h270f;
	// read timing codes
	localparam logic [3:0]  TIMING_ALWAYS    = 4'h0;
	localparam logic [3:0]  TIMING_STROBED   = 4'h1;
	localparam logic [3:0]  TIMING_FILTERED  = 4'ha;
	localparam logic [3:0]  TIMING_RESET     = 4'h0;
	// frequencies in 0.01 Hz units
	localparam logic [15:0] GAIN_DIRECT      = 16'h270f;
	localparam logic [15:0] FREQ_MAX         = 16'h9c40;
	localparam logic [15:0] GAIN_RESET       = 16'h1770;
	localparam logic [15:0] BIAS_RESET       = 16'h0000;
	localparam logic [1:0]  INCR_RESET       = 2'h1;
	// full scale values
	localparam logic [15:0] FS_BCD3          = 16'h03e7;
	localparam logic [15:0] FS_BCD4          = 16'h270f;
	localparam logic [15:0] FS_BIN12         = 16'h0fff;
	localparam logic [15:0] FS_BIN16         = 16'hffff;
	// skew filter: input must hold this long before it is taken
	localparam int          FILTER_NS        = 1000;
	localparam int          CLK_NS           = 4;
	localparam int          FILTER_CYCLES    = (FILTER_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0]  FILTER_LAST      = 8'(FILTER_CYCLES - 1);
	// sequencer of the linear map divider
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DIVIDE = 2'b01,
		ST_DONE   = 2'b10
	} map_state_t;
endpackage

// *** verilog/freq_divider.sv ***
// restoring divider for the linear frequency map
`timescale 1ns/100ps
module freq_divider (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             busy,
	output logic             done,
	output logic [31:0]      quotient
);
	logic [31:0] quo;
	logic [31:0] next_quo;
	logic [16:0] rem;
	logic [16:0] next_rem;
	logic [5:0]  cnt;
	logic [5:0]  next_cnt;
	logic        next_busy;
	logic        next_done;
	logic [16:0] trial;

	always_comb begin
		next_quo  = quo;
		next_rem  = rem;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		trial     = {rem[15:0], quo[31]};
		if (start) begin
			next_quo  = dividend;
			next_rem  = 17'h00000;
			next_cnt  = 6'h20;
			next_busy = 1'b1;
		end else if (busy) begin
			if (trial >= {1'b0, divisor}) begin
				next_rem = trial - {1'b0, divisor};
				next_quo = {quo[30:0], 1'b1};
			end else begin
				next_rem = trial;
				next_quo = {quo[30:0], 1'b0};
			end
			next_cnt = cnt - 6'h01;
			if (cnt == 6'h01) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			quo  <= 32'h00000000;
			rem  <= 17'h00000;
			cnt  <= 6'h00;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			quo  <= next_quo;
			rem  <= next_rem;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign quotient = quo;
endmodule

// *** verilog/digital_frequency_input.sv ***
// parallel digital input to frequency command front end
//
// Function
// - decode method: 0,2 BCD3; 1,3 bin12; 10,12 BCD4; 11,13 bin16; 9999 off
// - methods 2,3,12,13 enable analog compensation; others leave it off
// - methods 0 to 3 ignore input lines 12 to 15
// - timing 0 samples lines continuously, no strobe, no filter
// - timing 1 imports lines only while strobe is asserted
// - timing 1 holds last captured data while strobe is deasserted
// - timing 10 samples continuously through a skew masking filter
// - timing 1 with strobe off since power up treats lines as zero
// - zero input gives bias frequency of the selected encoding
// - full scale input gives gain frequency of the selected encoding
// - gains reset to 60 Hz; bias and gain 0 to 400 Hz, 0.01 Hz
// - gain 9999 uses decoded value directly as frequency
// - direct mode does not apply the bias
// - BCD digit above 9 is invalid; previous value kept
// - direct mode multiplies by 10, 1, 0.1 or 0.01 Hz per setting
`timescale 1ns/100ps
module digital_frequency_input
	import dfi_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [15:0] parallel_input_lines,
	input  wire logic        data_read_strobe,
	input  wire logic [13:0] input_method_select,
	input  wire logic [3:0]  read_timing_select,
	input  wire logic [15:0] bcd_bias_freq,
	input  wire logic [15:0] bcd_gain_freq,
	input  wire logic [15:0] binary_bias_freq,
	input  wire logic [15:0] binary_gain_freq,
	input  wire logic [1:0]  direct_increment_select,
	output logic             digital_enable,
	output logic             compensation_enable,
	output logic [15:0]      decoded_value,
	output logic [31:0]      freq_command,
	output logic             freq_valid
);
	import dfi_pkg::*;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic is_bcd(input logic [13:0] m);
		is_bcd = (m == METHOD_BCD3) || (m == METHOD_BCD3_CMP) ||
			(m == METHOD_BCD4) || (m == METHOD_BCD4_CMP);
	endfunction

	function automatic logic is_narrow(input logic [13:0] m);
		is_narrow = (m <= METHOD_BIN12_CMP);
	endfunction

	function automatic logic is_valid_method(input logic [13:0] m);
		is_valid_method = (m <= METHOD_BIN12_CMP) ||
			((m >= METHOD_BCD4) && (m <= METHOD_BIN16_CMP));
	endfunction

	function automatic logic [15:0] clamp_freq(input logic [15:0] f);
		clamp_freq = (f > FREQ_MAX) ? FREQ_MAX : f;
	endfunction

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [15:0] linesMeta;
	logic [15:0] linesSync;
	logic        strobeMeta;
	logic        strobeSync;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			linesMeta  <= 16'h0000;
			linesSync  <= 16'h0000;
			strobeMeta <= 1'b0;
			strobeSync <= 1'b0;
		end else begin
			linesMeta  <= parallel_input_lines;
			linesSync  <= linesMeta;
			strobeMeta <= data_read_strobe;
			strobeSync <= strobeMeta;
		end
	end

	// ------------------------------------------------------------------
	// method decode
	// ------------------------------------------------------------------
	logic        bcdMode;
	logic        narrowMode;
	logic        methodOn;
	logic [15:0] maskedLines;

	always_comb begin
		methodOn   = is_valid_method(input_method_select);
		bcdMode    = is_bcd(input_method_select);
		narrowMode = is_narrow(input_method_select);
		maskedLines = narrowMode ? {4'h0, linesSync[11:0]} : linesSync;
	end

	// ------------------------------------------------------------------
	// read timing: pass, strobe latch, skew filter
	// ------------------------------------------------------------------
	logic [15:0] sampled;
	logic [15:0] next_sampled;
	logic [15:0] filterRef;
	logic [15:0] next_filterRef;
	logic [7:0]  filterCnt;
	logic [7:0]  next_filterCnt;

	always_comb begin
		next_sampled   = sampled;
		next_filterRef = maskedLines;
		next_filterCnt = 8'h00;
		case (read_timing_select)
			TIMING_ALWAYS: begin
				next_sampled = maskedLines;
			end
			TIMING_STROBED: begin
				// sampled starts at zero and waits for the strobe
				if (strobeSync) begin
					next_sampled = maskedLines;
				end
				// else hold
			end
			TIMING_FILTERED: begin
				// accept only once lines held still for the window
				if (maskedLines != filterRef) begin
					next_filterCnt = 8'h00;
				end else if (filterCnt == FILTER_LAST) begin
					next_filterCnt = filterCnt;
					next_sampled   = maskedLines;
				end else begin
					next_filterCnt = filterCnt + 8'h01;
				end
			end
			default: begin
				next_sampled = maskedLines;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sampled   <= 16'h0000;
			filterRef <= 16'h0000;
			filterCnt <= 8'h00;
		end else begin
			sampled   <= next_sampled;
			filterRef <= next_filterRef;
			filterCnt <= next_filterCnt;
		end
	end

	// ------------------------------------------------------------------
	// BCD / binary decode with invalid digit hold
	// ------------------------------------------------------------------
	logic        digitsOk;
	logic [15:0] bcdValue;
	logic [15:0] next_value;
	logic [15:0] value;

	always_comb begin
		digitsOk = 1'b1;
		for (int d = 0; d < 4; d++) begin
			if (sampled[4*d +: 4] > 4'h9) begin
				digitsOk = 1'b0;
			end
		end
		bcdValue = 16'({12'h000, sampled[15:12]} * 16'd1000 +
			{12'h000, sampled[11:8]} * 16'd100 +
			{12'h000, sampled[7:4]} * 16'd10 +
			{12'h000, sampled[3:0]});
		next_value = value;
		if (!methodOn) begin
			next_value = 16'h0000;
		end else if (!bcdMode) begin
			next_value = sampled;
		end else if (digitsOk) begin
			next_value = bcdValue;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			value <= 16'h0000;
		end else begin
			value <= next_value;
		end
	end

	// ------------------------------------------------------------------
	// frequency map
	// ------------------------------------------------------------------
	logic [15:0] bias;
	logic [15:0] gain;
	logic [15:0] fullScale;
	logic        direct;
	logic [31:0] directFreq;
	logic [31:0] span;
	logic        spanNeg;
	logic [31:0] product;
	logic        divStart;
	logic        divBusy;
	logic        divDone;
	logic [31:0] quot;
	logic [15:0] latchedValue;
	logic [15:0] next_latchedValue;
	logic [31:0] next_freq;
	logic        next_valid;
	map_state_t  state;
	map_state_t  next_state;

	always_comb begin
		bias = clamp_freq(bcdMode ? bcd_bias_freq : binary_bias_freq);
		gain = bcdMode ? bcd_gain_freq : binary_gain_freq;
		direct = (gain == GAIN_DIRECT);
		if (bcdMode) begin
			fullScale = narrowMode ? FS_BCD3 : FS_BCD4;
		end else begin
			fullScale = narrowMode ? FS_BIN12 : FS_BIN16;
		end
		// result in 0.01 Hz units, no bias
		case (direct_increment_select)
			2'h0:    directFreq = {16'h0000, latchedValue} * 32'd1000;
			2'h1:    directFreq = {16'h0000, latchedValue} * 32'd100;
			2'h2:    directFreq = {16'h0000, latchedValue} * 32'd10;
			default: directFreq = {16'h0000, latchedValue};
		endcase
		spanNeg = clamp_freq(gain) < bias;
		span = spanNeg ? {16'h0000, bias - clamp_freq(gain)} :
			{16'h0000, clamp_freq(gain) - bias};
		product = span * {16'h0000, latchedValue};
	end

	always_comb begin
		next_state        = state;
		next_latchedValue = latchedValue;
		next_freq         = freq_command;
		next_valid        = freq_valid;
		divStart          = 1'b0;
		case (state)
			ST_IDLE: begin
				next_latchedValue = value;
				next_state        = ST_DIVIDE;
			end
			ST_DIVIDE: begin
				if (!methodOn) begin
					next_freq  = 32'h00000000;
					next_valid = 1'b0;
					next_state = ST_IDLE;
				end else if (direct) begin
					next_freq  = directFreq;
					next_valid = 1'b1;
					next_state = ST_IDLE;
				end else if (!divBusy) begin
					divStart   = 1'b1;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (divDone) begin
					next_freq  = spanNeg ? {16'h0000, bias} - quot :
						{16'h0000, bias} + quot;
					next_valid = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// off wins at once, even mid divide
		if (!methodOn) begin
			next_freq  = 32'h00000000;
			next_valid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state        <= ST_IDLE;
			latchedValue <= 16'h0000;
			freq_command <= 32'h00000000;
			freq_valid   <= 1'b0;
		end else begin
			state        <= next_state;
			latchedValue <= next_latchedValue;
			freq_command <= next_freq;
			freq_valid   <= next_valid;
		end
	end

	freq_divider u_div (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.start    (divStart),
		.dividend (product),
		.divisor  (fullScale),
		.busy     (divBusy),
		.done     (divDone),
		.quotient (quot)
	);

	// ------------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			digital_enable      <= 1'b0;
			compensation_enable <= 1'b0;
			decoded_value       <= 16'h0000;
		end else begin
			digital_enable      <= methodOn;
			compensation_enable <= input_method_select inside
				{METHOD_BCD3_CMP, METHOD_BIN12_CMP,
				METHOD_BCD4_CMP, METHOD_BIN16_CMP};
			decoded_value       <= value;
		end
	end
endmodule

// *** testbench/dfi_monitor.sv ***
// port checks for the digital frequency input block
`timescale 1ns/100ps
module dfi_monitor
	import dfi_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [15:0] parallel_input_lines,
	input wire logic        data_read_strobe,
	input wire logic [13:0] input_method_select,
	input wire logic [3:0]  read_timing_select,
	input wire logic        digital_enable,
	input wire logic        compensation_enable,
	input wire logic [15:0] decoded_value,
	input wire logic        freq_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire cmpOn = input_method_select inside {METHOD_BCD3_CMP,
		METHOD_BIN12_CMP, METHOD_BCD4_CMP, METHOD_BIN16_CMP};
	wire cmpOff = input_method_select inside {METHOD_BCD3,
		METHOD_BIN12, METHOD_BCD4, METHOD_BIN16};
	wire bin16 = input_method_select == METHOD_BIN16;
	wire always0 = read_timing_select == TIMING_ALWAYS;
	wire strobed = read_timing_select == TIMING_STROBED;

	property p_off;
		(input_method_select == METHOD_OFF)[*8]
			|-> !digital_enable && !freq_valid;
	endproperty
	a_off: assert property (p_off)
		else $error("output live with method off");
	property p_cmp;
		cmpOn[*3] |-> compensation_enable;
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("compensation not enabled");
	property p_nocmp;
		cmpOff[*3] |-> !compensation_enable;
	endproperty
	a_nocmp: assert property (p_nocmp)
		else $error("compensation enabled wrongly");
	property p_mask;
		(always0 && input_method_select == METHOD_BIN12
			&& $stable(parallel_input_lines))[*8]
			|-> decoded_value == {4'h0, parallel_input_lines[11:0]};
	endproperty
	a_mask: assert property (p_mask)
		else $error("upper lines not ignored");
	property p_pass;
		(always0 && bin16 && $stable(parallel_input_lines))[*8]
			|-> decoded_value == parallel_input_lines;
	endproperty
	a_pass: assert property (p_pass)
		else $error("lines not passed through");
	property p_strobe;
		(strobed && data_read_strobe && bin16
			&& $stable(parallel_input_lines))[*8]
			|-> decoded_value == parallel_input_lines;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("strobed data not taken");
	property p_hold;
		(strobed && !data_read_strobe && $stable(input_method_select))[*8]
			|=> $stable(decoded_value);
	endproperty
	a_hold: assert property (p_hold)
		else $error("value moved with strobe low");
	property p_filter;
		$changed(parallel_input_lines) ##1
			(read_timing_select == TIMING_FILTERED
			&& $stable(parallel_input_lines))[*8]
			|=> $stable(decoded_value);
	endproperty
	a_filter: assert property (p_filter)
		else $error("filter took unsettled lines");
endmodule

bind digital_frequency_input dfi_monitor u_monitor (.clk_sys, .rst_n,
	.parallel_input_lines, .data_read_strobe, .input_method_select,
	.read_timing_select, .digital_enable, .compensation_enable,
	.decoded_value, .freq_valid);

// *** testbench/plc_model.sv ***
// controller model driving the parallel lines and read strobe
`timescale 1ns/100ps
module plc_model (
	input  wire logic   clk_sys,
	output logic [15:0] lines,
	output logic        strobe
);
	initial begin
		lines = 16'h5a5a;
		strobe = 1'b0;
	end
	task automatic hold(input logic [15:0] v);
		@(posedge clk_sys);
		#1 lines = v;
	endtask
	// lines settle first and stay put while the strobe is up
	task automatic latch(input logic [15:0] v);
		hold(v);
		#12 strobe = 1'b1;
		#40 strobe = 1'b0;
		#16 lines = ~v;
	endtask
endmodule

// *** testbench/tb_digital_frequency_input.sv ***
// self-checking bench for the digital frequency input block
`timescale 1ns/100ps
module tb_digital_frequency_input;
	import dfi_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] lines;
	logic        strobe;
	logic [13:0] method = METHOD_BIN16;
	logic [3:0]  timing = TIMING_STROBED;
	logic [15:0] bias [2] = '{BIAS_RESET, 16'h07d0};
	logic [15:0] gain [2] = '{GAIN_RESET, GAIN_RESET};
	logic [1:0]  incr = INCR_RESET;
	logic        digEn, cmpEn, valid;
	logic [15:0] value;
	logic [31:0] freq;
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;
	int          scale [4] = '{1000, 100, 10, 1};
	logic [13:0] methods [8] = '{METHOD_BCD3, METHOD_BIN12,
		METHOD_BCD3_CMP, METHOD_BIN12_CMP, METHOD_BCD4,
		METHOD_BIN16, METHOD_BCD4_CMP, METHOD_BIN16_CMP};

	plc_model u_plc (.clk_sys(clk_sys), .lines(lines), .strobe(strobe));
	digital_frequency_input u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.parallel_input_lines(lines), .data_read_strobe(strobe),
		.input_method_select(method), .read_timing_select(timing),
		.bcd_bias_freq(bias[0]), .bcd_gain_freq(gain[0]),
		.binary_bias_freq(bias[1]), .binary_gain_freq(gain[1]),
		.direct_increment_select(incr), .digital_enable(digEn),
		.compensation_enable(cmpEn), .decoded_value(value),
		.freq_command(freq), .freq_valid(valid));

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// ----
	// model and comparison
	// ----
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [15:0] bcd(int v);
		return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	function automatic int fullscale();
		return method[0] ? (method > 9 ? 65535 : 4095)
			: (method > 9 ? 9999 : 999);
	endfunction
	task automatic settle(int v);
		bit     bin = method[0];
		longint b = bias[bin];
		longint g = gain[bin];
		longint f = g == 9999 ? v * scale[incr]
			: g >= b ? b + (g - b) * v / fullscale()
			: b - (b - g) * v / fullscale();
		for (int k = 0; k < 80 && (freq !== 32'(f) || value !== 16'(v)
			|| valid !== 1'b1); k++)
			#4;
		check("value", 32'(value), 32'(v));
		check("freq", freq, 32'(f));
		check("valid", 32'(valid), 1);
		check("enable", 32'(digEn), 1);
		check("comp", 32'(cmpEn), 32'(method inside {2, 3, 12, 13}));
	endtask

	// ----
	// sequence
	// ----
	initial begin
		logic [15:0] pins;
		int          v;
		int          w;
		void'($urandom(32'h1b7c7993));
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		settle(0);
		timing = TIMING_ALWAYS;
		for (int i = 0; i < 24; i++) begin
			method = methods[i % 8];
			v = i % 3 == 0 ? 0 : i % 3 == 1 ? fullscale()
				: $urandom_range(fullscale());
			bias[method[0]] = 16'($urandom_range(40000));
			gain[method[0]] = i % 5 == 3 ? 16'h270f
				: 16'($urandom_range(40000));
			incr = 2'($urandom_range(3));
			pins = method[0] ? 16'(v) : bcd(v);
			if (method < 4)
				pins[15:12] = 4'($urandom);
			u_plc.hold(pins);
			settle(v);
			if (i % 8 == 4) begin
				u_plc.hold(pins | 16'h00a0);
				#160;
				settle(v);
			end
		end
		method = METHOD_OFF;
		#160;
		check("enable", 32'(digEn), 0);
		check("valid", 32'(valid), 0);
		check("freq", freq, 0);
		method = METHOD_BIN16;
		timing = TIMING_STROBED;
		v = $urandom_range(65535);
		u_plc.latch(16'(v));
		#160;
		settle(v);
		timing = TIMING_FILTERED;
		#1200;
		w = v ^ 65535;
		settle(w);
		v = $urandom_range(65535);
		u_plc.hold(16'(v));
		#400;
		check("filtered", 32'(value), 32'(w));
		#800;
		settle(v);
		complete_run();
	end
endmodule
